// ---- core/mtb_duty_gen.sv ----
`timescale 1ns/1ps
module mtb_duty_gen (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   ce,
  mtb_duty_if.gen     dif
);
  import mtb_pkg::*;

  logic [15:0] buf_reg;
  logic [15:0] act_reg;
  logic        high_reg;

  // ****************************************
  // Double-buffered duty value
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg <= DUTY_RST;
    end else if (ce && dif.wr) begin
      buf_reg <= dif.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= DUTY_RST;
    end else if (ce && dif.load) begin
      act_reg <= buf_reg; // R22
    end
  end

  // ****************************************
  // Edge-aligned compare
  // ****************************************
  // Active from count zero until count reaches duty; zero duty never active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_reg <= 1'b0;
    end else if (ce) begin
      high_reg <= act_reg > {1'b0, dif.count}; // R19 R20
    end
  end

  assign dif.duty     = buf_reg;
  assign dif.out_high = high_reg;
  assign dif.out_low  = ~high_reg; // R21
endmodule : mtb_duty_gen

// ---- core/mtb_duty_if.sv ----
`timescale 1ns/1ps
interface mtb_duty_if;
  logic [14:0] count;
  logic        load;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] duty;
  logic        out_high;
  logic        out_low;

  modport ctrl (output count, output load, output wr, output wdata,
                input duty, input out_high, input out_low);
  modport gen  (input count, input load, input wr, input wdata,
                output duty, output out_high, output out_low);
endinterface : mtb_duty_if

// ---- core/mtb_pkg.sv ----
package mtb_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_DUTY0  = 8'h0C;
  localparam int         NUM_DUTY    = 4;
  localparam int         CNT_W       = 15;
  localparam int         DUTY_W      = 16;

  // ****************************************
  // Control field layout
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PRE_LSB  = 2;
  localparam int CTRL_POST_LSB = 4;
  localparam int CTRL_UPDATE_DISABLE_BIT = 8;
  localparam int CTRL_EN_BIT   = 15;
  localparam int CNT_DIR_BIT   = 15;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [14:0] COUNT_RST  = 15'h0000;
  localparam logic [14:0] PERIOD_RST = 15'h0000;
  localparam logic [15:0] DUTY_RST   = 16'h0000;
  localparam logic [5:0]  PRE_RST    = 6'h00;
  localparam logic [3:0]  POST_RST   = 4'h0;

  // ****************************************
  // Counting modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_FREE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_DOUBLE = 2'h3
  } mtb_mode_t;
endpackage : mtb_pkg

// ---- core/mtb_time_base.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] 15-bit count, bit 15 reads direction
// [R2] Enable bit starts and stops counting
// [R3] Period match resets or reverses next tick
// [R4] Zero period stops counter, no events
// [R5] Software disables before changing zero period
// [R6] Two-bit mode selects four counting modes
// [R7] Free-running wraps at match, postscaled events
// [R8] Single-shot clears enable, one event
// [R9] Up/down reverses at match, flag set
// [R10] Up/down event at zero, postscaled
// [R11] Double-update events at zero and match
// [R12] Software avoids period one in double-update
// [R13] Prescaler divides by 1, 4, 16, 64
// [R14] Count or control write clears prescaler
// [R15] Four-bit postscaler divides 1 to 16
// [R16] Count or control write clears postscaler
// [R17] Period buffer copied at reset/zero
// [R18] Disabled time base copies period continuously
// [R19] Output active at zero, off at duty
// [R20] Zero duty off, large duty on
// [R21] Four generators drive eight paired pins
// [R22] Duty loads at match reset or disabled; the disabled load is skipped while update_disable is set
// [R23] Prescale codes map; postscale n divides n+1
// [R24] Count write loads low fifteen bits
module mtb_time_base #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [mtb_pkg::NUM_DUTY-1:0] high_output,
  output logic [mtb_pkg::NUM_DUTY-1:0] low_output,
  output logic                   interrupt_event
);
  import mtb_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] time_base_control_reg;
  logic [14:0] count_reg;
  logic        dir_reg;
  logic [14:0] period_buf_reg;
  logic [14:0] period_act_reg;
  logic [5:0]  pre_cnt_reg;
  logic [3:0]  post_cnt_reg;
  logic        event_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [NUM_DUTY-1:0] high_reg;
  logic [NUM_DUTY-1:0] low_reg;

  logic        access;
  logic        wr_en;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_period;
  logic        tb_enable;
  mtb_mode_t   mode;
  logic [1:0]  prescale_select;
  logic [3:0]  postscale_select;
  logic        update_disable;
  logic        pre_hit;
  logic        tick;
  logic        match;
  logic        edge_mode;
  logic        base_event;
  logic        direct_event;
  logic        restart;
  logic        bottom;
  logic [NUM_DUTY-1:0] duty_wr;
  logic [15:0] duty_rd [NUM_DUTY];
  logic [NUM_DUTY-1:0] gen_high;
  logic [NUM_DUTY-1:0] gen_low;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [5:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_last = 6'h00; // R23
      2'h1:    pre_last = 6'h03;
      2'h2:    pre_last = 6'h0F;
      2'h3:    pre_last = 6'h3F;
      default: pre_last = 6'h00;
    endcase
  endfunction : pre_last

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction : addr_is

  // ****************************************
  // Field decode
  // ****************************************
  assign tb_enable        = time_base_control_reg[CTRL_EN_BIT];
  assign mode             = mtb_mode_t'(time_base_control_reg[CTRL_MODE_LSB +: 2]); // R6
  assign prescale_select  = time_base_control_reg[CTRL_PRE_LSB +: 2];
  assign postscale_select = time_base_control_reg[CTRL_POST_LSB +: 4];
  assign update_disable   = time_base_control_reg[CTRL_UPDATE_DISABLE_BIT];
  assign edge_mode        = (mode == MODE_FREE) || (mode == MODE_SINGLE);

  // ****************************************
  // APB slave
  // ****************************************
  assign access    = psel && penable && pready_reg;
  assign wr_en     = ce && access && pwrite;
  assign wr_ctrl   = wr_en && addr_is(paddr, ADDR_CTRL);
  assign wr_count  = wr_en && addr_is(paddr, ADDR_COUNT);
  assign wr_period = wr_en && addr_is(paddr, ADDR_PERIOD);

  always_comb begin
    duty_wr = '0;
    for (int i = 0; i < NUM_DUTY; i++) begin
      duty_wr[i] = wr_en && addr_is(paddr, 8'(ADDR_DUTY0 + 8'(4 * i)));
    end
  end

  // One wait state, then answer with registered data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else if (ce) begin
      pready_reg <= psel && penable && !pready_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce && psel && penable && !pready_reg) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      if (addr_is(paddr, ADDR_CTRL)) begin
        prdata_reg[15:0] <= time_base_control_reg;
      end else if (addr_is(paddr, ADDR_COUNT)) begin
        prdata_reg[15:0] <= {dir_reg, count_reg}; // R1
      end else if (addr_is(paddr, ADDR_PERIOD)) begin
        prdata_reg[15:0] <= {1'b0, period_buf_reg};
      end else begin
        pslverr_reg <= 1'b1;
        for (int i = 0; i < NUM_DUTY; i++) begin
          if (addr_is(paddr, 8'(ADDR_DUTY0 + 8'(4 * i)))) begin
            prdata_reg[15:0] <= duty_rd[i];
            pslverr_reg      <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base_control_reg <= CTRL_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        time_base_control_reg <= pwdata[15:0]; // R2
      end else if (tick && match && mode == MODE_SINGLE) begin
        time_base_control_reg[CTRL_EN_BIT] <= 1'b0; // R8
      end
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  assign pre_hit = (pre_cnt_reg == pre_last(prescale_select)); // R13
  assign tick    = ce && tb_enable && pre_hit && (period_act_reg != 15'h0000); // R4
  assign match   = (count_reg == period_act_reg); // R3
  assign bottom  = (count_reg == 15'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= PRE_RST;
    end else if (ce) begin
      if (wr_ctrl || wr_count || !tb_enable || pre_hit) begin
        pre_cnt_reg <= PRE_RST; // R14
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 6'h01;
      end
    end
  end

  // ****************************************
  // Counter and direction
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= COUNT_RST;
      dir_reg   <= 1'b0;
    end else if (ce) begin
      if (wr_count) begin
        count_reg <= pwdata[14:0]; // R24
      end else if (tick) begin
        if (edge_mode) begin
          dir_reg   <= 1'b0;
          count_reg <= match ? COUNT_RST : count_reg + 15'h0001; // R7
        end else if (!dir_reg && match) begin
          dir_reg   <= 1'b1; // R9
          count_reg <= count_reg - 15'h0001;
        end else if (dir_reg && bottom) begin
          dir_reg   <= 1'b0;
          count_reg <= count_reg + 15'h0001;
        end else if (dir_reg) begin
          count_reg <= count_reg - 15'h0001;
        end else begin
          count_reg <= count_reg + 15'h0001;
        end
      end
    end
  end

  // ****************************************
  // Events and postscaler
  // ****************************************
  // Restart instant: wrap in edge modes, bottom turn in up/down modes
  assign restart = tick && (edge_mode ? match : (dir_reg && bottom));
  assign base_event   = tick && ((mode == MODE_FREE && match) ||
                                 (mode == MODE_UPDOWN && dir_reg && bottom)); // R10
  assign direct_event = tick && ((mode == MODE_SINGLE && match) ||
                                 (mode == MODE_DOUBLE &&
                                  ((!dir_reg && match) || (dir_reg && bottom)))); // R8 R11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_reg <= POST_RST;
    end else if (ce) begin
      if (wr_ctrl || wr_count) begin
        post_cnt_reg <= POST_RST; // R16
      end else if (base_event) begin
        post_cnt_reg <= (post_cnt_reg == postscale_select) ? POST_RST
                                                           : post_cnt_reg + 4'h1; // R15
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_reg <= 1'b0;
    end else if (ce) begin
      event_reg <= direct_event ||
                   (base_event && post_cnt_reg == postscale_select); // R23
    end
  end

  // ****************************************
  // Period buffering
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_buf_reg <= PERIOD_RST;
    end else if (ce && wr_period) begin
      period_buf_reg <= pwdata[14:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_act_reg <= PERIOD_RST;
    end else if (ce) begin
      if (!tb_enable) begin
        period_act_reg <= period_buf_reg; // R18
      end else if (restart) begin
        period_act_reg <= period_buf_reg; // R17
      end
    end
  end

  // ****************************************
  // Duty generators
  // ****************************************
  for (genvar g = 0; g < NUM_DUTY; g++) begin : g_duty
    mtb_duty_if dif ();
    assign dif.count = count_reg;
    assign dif.wr    = duty_wr[g];
    assign dif.wdata = pwdata[15:0];
    assign dif.load  = (edge_mode && tick && match) ||
                       (!tb_enable && !update_disable); // R22
    assign duty_rd[g]  = dif.duty;
    assign gen_high[g] = dif.out_high;
    assign gen_low[g]  = dif.out_low;
    mtb_duty_gen u_gen (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .dif     (dif)
    );
  end

  // Output pins are retimed so each comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_reg <= '0;
      low_reg  <= '0;
    end else if (ce) begin
      high_reg <= gen_high;
      low_reg  <= gen_low; // R21
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign high_output     = high_reg;
  assign low_output      = low_reg;
  assign interrupt_event = event_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_zero_period: assert property ( // R4
    ce && tb_enable && period_act_reg == 15'h0000 && !wr_count
    |=> $stable(count_reg) && !interrupt_event)
    else $error("counter moved with zero period");
  chk_disable_hold: assert property ( // R2
    ce && !tb_enable && !wr_count |=> $stable(count_reg))
    else $error("count changed while disabled");
  chk_free_wrap: assert property ( // R7
    tick && mode == MODE_FREE && match && !wr_count |=> count_reg == 15'h0000)
    else $error("free mode did not wrap to zero");
  chk_single_stop: assert property ( // R8
    tick && mode == MODE_SINGLE && match && !wr_ctrl
    |=> !tb_enable && interrupt_event)
    else $error("single shot did not stop with event");
  chk_updown_turn: assert property ( // R9
    tick && !edge_mode && !dir_reg && match && !wr_count
    |=> dir_reg && count_reg == $past(period_act_reg) - 15'h0001)
    else $error("up/down did not reverse at match");
  chk_double_event: assert property ( // R11
    tick && mode == MODE_DOUBLE && !dir_reg && match |=> interrupt_event)
    else $error("double update missed match event");
  chk_period_copy: assert property ( // R18
    ce && !tb_enable |=> period_act_reg == $past(period_buf_reg))
    else $error("period not copied while disabled");
  chk_pre_clear: assert property ( // R14
    wr_ctrl || wr_count |=> pre_cnt_reg == PRE_RST && post_cnt_reg == POST_RST)
    else $error("scaler counters not cleared by write");
  chk_count_load: assert property ( // R24
    wr_count |=> count_reg == $past(pwdata[14:0]) && $stable(dir_reg))
    else $error("count write not loaded");
  chk_apb_answer: assert property (
    ce && psel && penable && !pready_reg |=> pready_reg)
    else $error("apb answer late");

  cov_free_event: cover property (mode == MODE_FREE && interrupt_event);
  cov_single_done: cover property (mode == MODE_SINGLE && $fell(tb_enable));
  cov_updown_turn: cover property (!edge_mode && $rose(dir_reg));
  cov_pwm_pulse: cover property ($rose(high_output[0]) ##[1:200] $fell(high_output[0]));
endmodule : mtb_time_base

// ---- sim/mtb_gate_model.sv ----
`timescale 1ns/1ps
module mtb_gate_model (
  input  wire logic        pclk,
  input  wire logic        clr,
  input  wire logic [3:0]  high_output,
  input  wire logic [3:0]  low_output,
  output logic [3:0][15:0] on_cnt,
  output logic             fault
);
  // ****************************************
  // Upper switch on-time per pair
  // ****************************************
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (clr) on_cnt[i] <= 16'h0000;
      else if (high_output[i]) on_cnt[i] <= on_cnt[i] + 16'h0001;
    end
  end

  // ****************************************
  // Pair with both or neither switch on
  // ****************************************
  always @(posedge pclk) begin
    if (clr) fault <= 1'b0;
    else if (low_output !== ~high_output) fault <= 1'b1;
  end
endmodule : mtb_gate_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  import mtb_pkg::*;
  typedef struct packed {logic err; logic rd; logic [31:0] d;} mtb_note_t;
  logic             pclk, presetn, psel, penable, pwrite, clr, ce;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata;
  logic             pready, pslverr, interrupt_event, fault;
  logic [3:0]       high_output, low_output;
  logic [3:0][15:0] on_cnt;
  int               errors, check_count, cyc, irqs, t0, p, n0;
  mtb_note_t        notes[$];

  mtb_time_base #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_output(high_output),
    .low_output(low_output), .interrupt_event(interrupt_event));
  mtb_gate_model gates (.pclk(pclk), .clr(clr), .high_output(high_output),
    .low_output(low_output), .on_cnt(on_cnt), .fault(fault));

  // ****************************************
  // Checking and closing
  // ****************************************
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task stop_test;
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // ****************************************
  // APB master
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    notes.push_back('{err, !w, d});
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] cw(logic en, logic [3:0] post, logic [1:0] pre,
                                     mtb_mode_t m);
    return {16'h0000, en, 7'h00, post, pre, m};
  endfunction : cw

  always @(posedge pclk) begin
    mtb_note_t e;
    cyc <= cyc + 1;
    if (interrupt_event === 1'b1) irqs <= irqs + 1;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      e = notes.pop_front();
      check("pslverr", {31'h0, e.err}, {31'h0, pslverr});
      if (e.rd) check("prdata", e.d, prdata);
    end
  end

  task wait_irq;
    int n;
    n = 0;
    @(posedge pclk);
    while (interrupt_event !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) errors++;
  endtask : wait_irq

  // First event may still belong to the old setting, so it is skipped
  task gap(input int exp);
    wait_irq();
    wait_irq();
    t0 = cyc;
    wait_irq();
    check("irq_gap", 32'(exp), 32'(cyc - t0));
  endtask : gap

  // ****************************************
  // Clock, watchdog, scenarios
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0; check_count = 0; cyc = 0; irqs = 0; clr = 1'b1; ce = 1'b1;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    void'($urandom(88954));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CTRL, 32'h0, 0);
    apb(0, ADDR_COUNT, 32'h0, 0);
    apb(0, ADDR_PERIOD, 32'h0, 0);
    apb(0, 8'h40, 32'h0, 1);
    apb(1, 8'h40, 32'hFFFF, 1);
    apb(1, ADDR_PERIOD, 32'h5, 0);
    apb(1, ADDR_DUTY0, 32'h3, 0);
    apb(1, ADDR_DUTY0 + 8'h04, 32'h0, 0);
    apb(1, ADDR_DUTY0 + 8'h08, 32'h6, 0);
    apb(1, ADDR_DUTY0 + 8'h0C, 32'h5, 0);
    apb(1, ADDR_CTRL, cw(1, 0, 0, MODE_FREE), 0);
    gap(6);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (60) @(posedge pclk);
    #1;
    check("on_time0", 32'd30, {16'h0, on_cnt[0]});
    check("on_time1", 32'd0, {16'h0, on_cnt[1]});
    check("on_time2", 32'd60, {16'h0, on_cnt[2]});
    check("on_time3", 32'd50, {16'h0, on_cnt[3]});
    check("pair_fault", 32'h0, {31'h0, fault});
    apb(1, ADDR_CTRL, cw(1, 2, 0, MODE_FREE), 0);
    gap(18);
    for (int k = 1; k < 4; k++) begin
      apb(1, ADDR_CTRL, cw(1, 0, 2'(k), MODE_FREE), 0);
      gap(6 << (2 * k));
    end
    apb(1, ADDR_CTRL, cw(1, 0, 0, MODE_FREE), 0);
    repeat (2) begin
      p = 3 + int'($urandom % 20);
      apb(1, ADDR_PERIOD, 32'(p), 0);
      gap(p + 1);
    end
    apb(1, ADDR_PERIOD, 32'h4, 0);
    apb(1, ADDR_CTRL, cw(1, 0, 0, MODE_UPDOWN), 0);
    gap(8);
    apb(1, ADDR_CTRL, cw(1, 1, 0, MODE_UPDOWN), 0);
    gap(16);
    apb(1, ADDR_CTRL, cw(1, 2, 0, MODE_DOUBLE), 0);
    gap(4);
    // Clock enable low freezes the running time base
    wait_irq();
    ce <= 1'b0;
    @(posedge pclk);
    n0 = irqs;
    repeat (30) @(posedge pclk);
    check("frozen_irqs", 32'd0, 32'(irqs - n0));
    ce <= 1'b1;
    apb(1, ADDR_CTRL, cw(0, 3, 0, MODE_SINGLE), 0);
    apb(1, ADDR_COUNT, 32'h0, 0);
    n0 = irqs;
    apb(1, ADDR_CTRL, cw(1, 3, 0, MODE_SINGLE), 0);
    repeat (40) @(posedge pclk);
    check("single_irqs", 32'd1, 32'(irqs - n0));
    apb(0, ADDR_CTRL, cw(0, 3, 0, MODE_SINGLE), 0);
    apb(0, ADDR_COUNT, 32'h0, 0);
    apb(1, ADDR_COUNT, 32'h8003, 0);
    apb(0, ADDR_COUNT, 32'h3, 0);
    apb(1, ADDR_PERIOD, 32'h0, 0);
    n0 = irqs;
    apb(1, ADDR_CTRL, cw(1, 0, 0, MODE_FREE), 0);
    repeat (50) @(posedge pclk);
    check("zero_irqs", 32'd0, 32'(irqs - n0));
    apb(0, ADDR_COUNT, 32'h3, 0);
    apb(1, ADDR_CTRL, cw(0, 0, 0, MODE_FREE), 0);
    apb(1, ADDR_PERIOD, 32'h7, 0);
    apb(0, ADDR_PERIOD, 32'h7, 0);
    apb(0, ADDR_COUNT, 32'h3, 0);
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule : tb
